//--- hdl/pab_port_b_regs.vh
// constants for the port b alternate function override block
`ifndef PAB_PORT_B_REGS_VH
`define PAB_PORT_B_REGS_VH

// port width and reset values of the port bits (tri-state after reset)
`define PAB_WIDTH        8
`define PAB_DIR_RST      8'h00
`define PAB_OUT_RST      8'h00
`define PAB_PIN_RST      8'h00

// field positions of the port b alternate functions
`define PAB_BIT_TIMER2_A 7
`define PAB_BIT_TIMER1_B 6
`define PAB_BIT_TIMER1_A 5
`define PAB_BIT_TIMER0_A 4
`define PAB_BIT_MISO     3
`define PAB_BIT_MOSI     2
`define PAB_BIT_SCK      1
`define PAB_BIT_SS       0

// pin change source number carried by port b bit 0
`define PAB_PCINT_BASE   8

`endif

//--- hdl/pab_sync2.v
// two flip-flop synchroniser for a vector of pad levels
`timescale 1ns/10ps

module pab_sync2 #(
  parameter WIDTH = 8
) (
  input  wire             mclk_i,
  input  wire             reset_i,
  input  wire             ce_i,
  input  wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;

  // stage1 is read by stage2 only, to keep metastability contained
  always @(posedge mclk_i) begin
    if (reset_i) begin
      stage1 <= {WIDTH{1'b0}};
      stage2 <= {WIDTH{1'b0}};
    end else if (ce_i) begin
      stage1 <= async_i;
      stage2 <= stage1;
    end
  end

  assign sync_o = stage2;

endmodule

//--- hdl/pab_pin_ovr.v
// per-pin override multiplexer for pull-up, driver, value and input enable
`timescale 1ns/10ps

module pab_pin_ovr (
  input  wire dir_bit_i,
  input  wire out_bit_i,
  input  wire global_pullup_disable_i,
  input  wire sleep_clamp_i,
  input  wire pullup_override_en_i,
  input  wire pullup_override_val_i,
  input  wire dir_override_en_i,
  input  wire dir_override_val_i,
  input  wire value_override_en_i,
  input  wire value_override_val_i,
  input  wire input_enable_override_en_i,
  input  wire input_enable_override_val_i,
  output wire pullup_o,
  output wire drive_en_o,
  output wire drive_val_o,
  output wire input_en_o
);

  wire normal_pullup;

  // pull-up only for input with output bit set and pull-ups not disabled
  assign normal_pullup = ~dir_bit_i & out_bit_i & ~global_pullup_disable_i;
  assign pullup_o      = pullup_override_en_i ? pullup_override_val_i
                                              : normal_pullup;

  // a set direction bit makes an output, a clear one an input
  assign drive_en_o = dir_override_en_i ? dir_override_val_i
                                        : dir_bit_i;

  // level only matters while the driver is enabled
  assign drive_val_o = value_override_en_i ? value_override_val_i
                                           : out_bit_i;

  // sleep clamps the input unless an alternate function keeps it alive
  assign input_en_o = input_enable_override_en_i ?
                      input_enable_override_val_i :
                      ~sleep_clamp_i;

endmodule

//--- hdl/pab_port_b.v
// port b pin logic with alternate function overrides for timers and spi
`timescale 1ns/10ps
`include "pab_port_b_regs.vh"

module pab_port_b (
  input  wire       mclk_i,
  input  wire       reset_i,
  input  wire       ce_i,
  // software access to the port bits
  input  wire       dir_wr_i,
  input  wire [7:0] dir_wdata_i,
  input  wire       out_wr_i,
  input  wire [7:0] out_wdata_i,
  input  wire       toggle_wr_i,
  input  wire [7:0] toggle_wdata_i,
  output reg  [7:0] dir_o,
  output reg  [7:0] out_o,
  output reg  [7:0] pin_value_o,
  // shared controls
  input  wire       global_pullup_disable_i,
  input  wire       sleep_clamp_i,
  // generic toggle override, one pulse per pin
  input  wire [7:0] toggle_override_en_i,
  // timer compare outputs and their enables
  input  wire       timer2_compare_a_en_i,
  input  wire       timer2_compare_a_out_i,
  input  wire       timer1_compare_b_en_i,
  input  wire       timer1_compare_b_out_i,
  input  wire       timer1_compare_a_en_i,
  input  wire       timer1_compare_a_out_i,
  input  wire       timer0_compare_a_en_i,
  input  wire       timer0_compare_a_out_i,
  // spi state and outputs
  input  wire       spi_enable_i,
  input  wire       spi_master_i,
  input  wire       spi_slave_out_i,
  input  wire       spi_master_out_i,
  input  wire       spi_sck_out_i,
  // pin change masks for sources 15..8 and the group enable
  input  wire [7:0] pin_change_mask_i,
  input  wire       pin_change_group_en_i,
  // alternate function inputs, unsynchronised
  output wire [7:0] alt_function_input_o,
  output wire [7:0] pin_change_source_o,
  output wire       spi_master_in_o,
  output wire       spi_slave_in_o,
  output wire       spi_sck_in_o,
  output wire       spi_ss_in_o,
  // pad controls
  input  wire [7:0] pad_in_i,
  output wire [7:0] pad_out_o,
  output wire [7:0] pad_oe_n_o,
  output wire [7:0] pad_pullup_o,
  output wire [7:0] pad_input_en_o
);

  reg  [7:0] next_dir;
  reg  [7:0] next_out;
  wire [7:0] pullup_override_en;
  wire [7:0] pullup_override_val;
  wire [7:0] dir_override_en;
  wire [7:0] dir_override_val;
  wire [7:0] value_override_en;
  wire [7:0] value_override_val;
  wire [7:0] input_enable_override_en;
  wire [7:0] input_enable_override_val;
  wire [7:0] pin_pullup;
  wire [7:0] pin_drive_en;
  wire [7:0] pin_drive_val;
  wire [7:0] pin_input_en;
  wire [7:0] schmitt_out;
  wire [7:0] pin_sync;
  wire       spi_as_master;
  wire       spi_as_slave;

  assign spi_as_master = spi_enable_i & spi_master_i;
  assign spi_as_slave  = spi_enable_i & ~spi_master_i;

  // next state of the port bits; a toggle write or toggle override
  // inverts the stored bit independent of the direction
  always @* begin
    next_dir = dir_o;
    next_out = out_o;
    if (dir_wr_i) begin
      next_dir = dir_wdata_i;
    end
    if (out_wr_i) begin
      next_out = out_wdata_i;
    end
    if (toggle_wr_i) begin
      next_out = next_out ^ toggle_wdata_i;
    end
    next_out = next_out ^ toggle_override_en_i;
  end

  // port bits reset to input without pull-up
  always @(posedge mclk_i) begin
    if (reset_i) begin
      dir_o <= `PAB_DIR_RST;
      out_o <= `PAB_OUT_RST;
    end else if (ce_i) begin
      dir_o <= next_dir;
      out_o <= next_out;
    end
  end

  // timer pins: only the value is overridden, so the direction bit
  // must be set by software before the compare output reaches the pad
  assign pullup_override_en[7:4]  = 4'h0;
  assign pullup_override_val[7:4] = 4'h0;
  assign dir_override_en[7:4]     = 4'h0;
  assign dir_override_val[7:4]    = 4'h0;
  assign value_override_en[`PAB_BIT_TIMER2_A]  = timer2_compare_a_en_i;
  assign value_override_val[`PAB_BIT_TIMER2_A] = timer2_compare_a_out_i;
  assign value_override_en[`PAB_BIT_TIMER1_B]  = timer1_compare_b_en_i;
  assign value_override_val[`PAB_BIT_TIMER1_B] = timer1_compare_b_out_i;
  assign value_override_en[`PAB_BIT_TIMER1_A]  = timer1_compare_a_en_i;
  assign value_override_val[`PAB_BIT_TIMER1_A] = timer1_compare_a_out_i;
  assign value_override_en[`PAB_BIT_TIMER0_A]  = timer0_compare_a_en_i;
  assign value_override_val[`PAB_BIT_TIMER0_A] = timer0_compare_a_out_i;

  // master-in pin: input as master, direction bit as slave; the pull-up
  // still follows the output bit while the pin is forced to input
  assign dir_override_en[`PAB_BIT_MISO]  = spi_as_master;
  assign dir_override_val[`PAB_BIT_MISO] = 1'b0;
  assign pullup_override_en[`PAB_BIT_MISO]  = spi_as_master;
  assign pullup_override_val[`PAB_BIT_MISO] =
    out_o[`PAB_BIT_MISO] & ~global_pullup_disable_i;
  assign value_override_en[`PAB_BIT_MISO]  = spi_as_slave;
  assign value_override_val[`PAB_BIT_MISO] = spi_slave_out_i;

  // master-out pin: input as slave, direction bit as master
  assign dir_override_en[`PAB_BIT_MOSI]  = spi_as_slave;
  assign dir_override_val[`PAB_BIT_MOSI] = 1'b0;
  assign pullup_override_en[`PAB_BIT_MOSI]  = spi_as_slave;
  assign pullup_override_val[`PAB_BIT_MOSI] =
    out_o[`PAB_BIT_MOSI] & ~global_pullup_disable_i;
  assign value_override_en[`PAB_BIT_MOSI]  = spi_as_master;
  assign value_override_val[`PAB_BIT_MOSI] = spi_master_out_i;

  // serial clock pin: input as slave, spi clock value with the direction bit as master
  assign dir_override_en[`PAB_BIT_SCK]  = spi_as_slave;
  assign dir_override_val[`PAB_BIT_SCK] = 1'b0;
  assign pullup_override_en[`PAB_BIT_SCK]  = spi_as_slave;
  assign pullup_override_val[`PAB_BIT_SCK] =
    out_o[`PAB_BIT_SCK] & ~global_pullup_disable_i;
  assign value_override_en[`PAB_BIT_SCK]  = spi_as_master;
  assign value_override_val[`PAB_BIT_SCK] = spi_sck_out_i;

  // slave select pin: input as slave, never value-overridden
  assign dir_override_en[`PAB_BIT_SS]  = spi_as_slave;
  assign dir_override_val[`PAB_BIT_SS] = 1'b0;
  assign pullup_override_en[`PAB_BIT_SS]  = spi_as_slave;
  assign pullup_override_val[`PAB_BIT_SS] =
    out_o[`PAB_BIT_SS] & ~global_pullup_disable_i;
  assign value_override_en[`PAB_BIT_SS]  = 1'b0;
  assign value_override_val[`PAB_BIT_SS] = 1'b0;

  // an enabled pin-change source keeps its input alive during sleep
  assign input_enable_override_en  = pin_change_mask_i &
                                     {8{pin_change_group_en_i}};
  assign input_enable_override_val = 8'hff;

  // one combinational mux per pin, no register in the control path
  genvar gi;
  generate
    for (gi = 0; gi < `PAB_WIDTH; gi = gi + 1) begin : g_pin
      pab_pin_ovr u_ovr (
        .dir_bit_i                   (dir_o[gi]),
        .out_bit_i                   (out_o[gi]),
        .global_pullup_disable_i     (global_pullup_disable_i),
        .sleep_clamp_i               (sleep_clamp_i),
        .pullup_override_en_i        (pullup_override_en[gi]),
        .pullup_override_val_i       (pullup_override_val[gi]),
        .dir_override_en_i           (dir_override_en[gi]),
        .dir_override_val_i          (dir_override_val[gi]),
        .value_override_en_i         (value_override_en[gi]),
        .value_override_val_i        (value_override_val[gi]),
        .input_enable_override_en_i  (input_enable_override_en[gi]),
        .input_enable_override_val_i (input_enable_override_val[gi]),
        .pullup_o                    (pin_pullup[gi]),
        .drive_en_o                  (pin_drive_en[gi]),
        .drive_val_o                 (pin_drive_val[gi]),
        .input_en_o                  (pin_input_en[gi])
      );
    end
  endgenerate

  // reset gates the driver and pull-up directly, so the pads float
  // even before the first clock edge has cleared the port bits
  assign pad_oe_n_o   = ~(pin_drive_en & {8{~reset_i}});
  assign pad_out_o    = pin_drive_val;
  assign pad_pullup_o = pin_pullup & {8{~reset_i}} &
                        ~pin_drive_en;
  assign pad_input_en_o = pin_input_en;

  // the analog path is wired at the pad ring itself; nothing of it
  // passes through this logic, so it stays usable both ways

  // clamp at the trigger input: a disabled input reads low
  assign schmitt_out = pad_in_i & pin_input_en;

  // alternate inputs tap the clamped level ahead of the synchroniser;
  // each consumer owns its own synchroniser unless it is a clock
  assign alt_function_input_o = schmitt_out;
  assign pin_change_source_o  = schmitt_out;
  assign spi_master_in_o = schmitt_out[`PAB_BIT_MISO];
  assign spi_slave_in_o  = schmitt_out[`PAB_BIT_MOSI];
  assign spi_sck_in_o    = schmitt_out[`PAB_BIT_SCK];
  assign spi_ss_in_o     = schmitt_out[`PAB_BIT_SS];

  // port read path, two flops against metastability
  pab_sync2 #(
    .WIDTH (`PAB_WIDTH)
  ) u_sync (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .ce_i    (ce_i),
    .async_i (schmitt_out),
    .sync_o  (pin_sync)
  );

  // registered copy for software reads; adds one cycle of latency
  always @(posedge mclk_i) begin
    if (reset_i) begin
      pin_value_o <= `PAB_PIN_RST;
    end else if (ce_i) begin
      pin_value_o <= pin_sync;
    end
  end

  // override signals come from each peripheral itself; only the clock,
  // sleep clamp and pull-up disable are shared across ports

endmodule

//--- bench/pab_periph_model.sv
// behavioural peripherals that drive the port b alternate outputs
`timescale 1ns/10ps

module pab_periph_model (
  input  wire mclk_i,
  input  wire reset_i,
  input  wire slow_i,
  output wire t2a_o,
  output wire t1b_o,
  output wire t1a_o,
  output wire t0a_o,
  output wire slave_out_o,
  output wire master_out_o,
  output wire sck_out_o
);
  reg  [9:0] cnt;
  wire [7:0] st;

  // free-running state; slow mode makes every output step four times slower
  always @(posedge mclk_i) begin
    if (reset_i)
      cnt <= 10'h000;
    else
      cnt <= cnt + 10'h001;
  end

  // each peripheral makes its own override values, new just after an edge
  assign st           = slow_i ? cnt[9:2] : cnt[7:0];
  assign t2a_o        = st[0];
  assign t1b_o        = st[1];
  assign t1a_o        = st[0] ^ st[2];
  assign t0a_o        = ~st[0];
  assign slave_out_o  = st[2];
  assign master_out_o = st[1] ^ st[0];
  assign sck_out_o    = st[0];
endmodule

//--- bench/pab_port_b_checker.sv
// pin-level assertions for the port b override block
`timescale 1ns/10ps

module pab_port_b_checker (
  input wire       mclk_i,
  input wire       reset_i,
  input wire       ce_i,
  input wire       out_wr_i,
  input wire       toggle_wr_i,
  input wire [7:0] dir_o,
  input wire [7:0] out_o,
  input wire [7:0] pin_value_o,
  input wire       global_pullup_disable_i,
  input wire       sleep_clamp_i,
  input wire [7:0] toggle_override_en_i,
  input wire       timer2_compare_a_en_i,
  input wire       timer2_compare_a_out_i,
  input wire       spi_enable_i,
  input wire       spi_master_i,
  input wire [7:0] pin_change_mask_i,
  input wire       pin_change_group_en_i,
  input wire [7:0] alt_function_input_o,
  input wire [7:0] pad_in_i,
  input wire [7:0] pad_out_o,
  input wire [7:0] pad_oe_n_o,
  input wire [7:0] pad_pullup_o,
  input wire [7:0] pad_input_en_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  // pad and its input enable held still long enough to cross the sync chain
  sequence s_quiet;
    (ce_i && $stable(pad_in_i) && $stable(pad_input_en_o)) [*4];
  endsequence

  property p_rst_tri;
    disable iff (1'b0) reset_i |-> pad_oe_n_o == 8'hff && pad_pullup_o == 8'h00;
  endproperty
  property p_plain_dir;
    !spi_enable_i |-> pad_oe_n_o == ~dir_o;
  endproperty
  property p_plain_pull;
    !spi_enable_i |->
      pad_pullup_o == (~dir_o & out_o & {8{~global_pullup_disable_i}});
  endproperty
  property p_cmp_val;
    timer2_compare_a_en_i && !pad_oe_n_o[7] |->
      pad_out_o[7] == timer2_compare_a_out_i;
  endproperty
  property p_miso_mst;
    spi_enable_i && spi_master_i |-> pad_oe_n_o[3] &&
      pad_pullup_o[3] == (out_o[3] & ~global_pullup_disable_i);
  endproperty
  property p_mosi_slv;
    spi_enable_i && !spi_master_i |-> pad_oe_n_o[2:0] == 3'h7;
  endproperty
  property p_toggle;
    ce_i && !out_wr_i && !toggle_wr_i |=>
      out_o == ($past(out_o) ^ $past(toggle_override_en_i));
  endproperty
  property p_in_en;
    pad_input_en_o == ((pin_change_mask_i & {8{pin_change_group_en_i}})
                       | {8{~sleep_clamp_i}});
  endproperty
  property p_alt_in;
    alt_function_input_o == (pad_in_i & pad_input_en_o);
  endproperty
  property p_read;
    s_quiet |-> pin_value_o == (pad_in_i & pad_input_en_o);
  endproperty

  a_rst_tri: assert property (p_rst_tri)
    else $error("pads not released during reset");
  a_plain_dir: assert property (p_plain_dir)
    else $error("driver enable differs from direction bits");
  a_plain_pull: assert property (p_plain_pull)
    else $error("pull-up wrong without override");
  a_cmp_val: assert property (p_cmp_val)
    else $error("compare value not on driven pin");
  a_miso_mst: assert property (p_miso_mst)
    else $error("master-in pin not input with output-bit pull-up");
  a_mosi_slv: assert property (p_mosi_slv)
    else $error("slave spi pins not forced to input");
  a_toggle: assert property (p_toggle)
    else $error("toggle override did not invert output bits");
  a_in_en: assert property (p_in_en)
    else $error("input enable wrong");
  a_alt_in: assert property (p_alt_in)
    else $error("alternate input not the gated pad level");
  a_read: assert property (p_read)
    else $error("pin value not the synchronised pad");
endmodule

bind pab_port_b pab_port_b_checker u_pab_port_b_checker (
  .mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce_i), .out_wr_i(out_wr_i),
  .toggle_wr_i(toggle_wr_i), .dir_o(dir_o), .out_o(out_o),
  .pin_value_o(pin_value_o),
  .global_pullup_disable_i(global_pullup_disable_i),
  .sleep_clamp_i(sleep_clamp_i),
  .toggle_override_en_i(toggle_override_en_i),
  .timer2_compare_a_en_i(timer2_compare_a_en_i),
  .timer2_compare_a_out_i(timer2_compare_a_out_i),
  .spi_enable_i(spi_enable_i), .spi_master_i(spi_master_i),
  .pin_change_mask_i(pin_change_mask_i),
  .pin_change_group_en_i(pin_change_group_en_i),
  .alt_function_input_o(alt_function_input_o), .pad_in_i(pad_in_i),
  .pad_out_o(pad_out_o), .pad_oe_n_o(pad_oe_n_o),
  .pad_pullup_o(pad_pullup_o), .pad_input_en_o(pad_input_en_o));

//--- bench/pab_port_b_test.sv
// self-checking bench for the port b override block
`timescale 1ns/10ps

module pab_port_b_test;
  reg        mclk_i, reset_i, ce_i, dir_wr_i, out_wr_i, toggle_wr_i;
  reg  [7:0] wdata, toggle_override_en_i, pin_change_mask_i, pad_in_i;
  reg        global_pullup_disable, sleep, spi_en, spi_mst, group_en, slow;
  reg  [3:0] cmp_en;
  wire [7:0] dir_o, out_o, pin_value_o, alt_in, pc_src;
  wire [7:0] pad_out_o, pad_oe_n_o, pad_pullup_o, pad_input_en_o;
  wire       m_in, s_in, sck_in, ss_in;
  wire       t2a, t1b, t1a, t0a, s_so, s_mo, s_sck;
  integer    n_fail, checks_done;

  pab_port_b u_pab_port_b (.mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce_i),
    .dir_wr_i(dir_wr_i), .dir_wdata_i(wdata), .out_wr_i(out_wr_i),
    .out_wdata_i(wdata), .toggle_wr_i(toggle_wr_i), .toggle_wdata_i(wdata),
    .dir_o(dir_o), .out_o(out_o), .pin_value_o(pin_value_o),
    .global_pullup_disable_i(global_pullup_disable), .sleep_clamp_i(sleep),
    .toggle_override_en_i(toggle_override_en_i),
    .timer2_compare_a_en_i(cmp_en[3]), .timer2_compare_a_out_i(t2a),
    .timer1_compare_b_en_i(cmp_en[2]), .timer1_compare_b_out_i(t1b),
    .timer1_compare_a_en_i(cmp_en[1]), .timer1_compare_a_out_i(t1a),
    .timer0_compare_a_en_i(cmp_en[0]), .timer0_compare_a_out_i(t0a),
    .spi_enable_i(spi_en), .spi_master_i(spi_mst), .spi_slave_out_i(s_so),
    .spi_master_out_i(s_mo), .spi_sck_out_i(s_sck),
    .pin_change_mask_i(pin_change_mask_i), .pin_change_group_en_i(group_en),
    .alt_function_input_o(alt_in), .pin_change_source_o(pc_src),
    .spi_master_in_o(m_in), .spi_slave_in_o(s_in), .spi_sck_in_o(sck_in),
    .spi_ss_in_o(ss_in), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o),
    .pad_oe_n_o(pad_oe_n_o), .pad_pullup_o(pad_pullup_o),
    .pad_input_en_o(pad_input_en_o));

  pab_periph_model u_pab_periph_model (.mclk_i(mclk_i), .reset_i(reset_i),
    .slow_i(slow), .t2a_o(t2a), .t1b_o(t1b), .t1a_o(t1a), .t0a_o(t0a),
    .slave_out_o(s_so), .master_out_o(s_mo), .sck_out_o(s_sck));

  always #10 mclk_i = ~mclk_i;

  task check(input [7:0] seen, input [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  // one write pulse: sel 0 direction, 1 output, 2 toggle
  task wr(input [1:0] sel, input [7:0] d);
    begin
      @(negedge mclk_i);
      dir_wr_i = (sel == 2'd0);
      out_wr_i = (sel == 2'd1);
      toggle_wr_i = (sel == 2'd2);
      wdata = d;
      @(negedge mclk_i);
      dir_wr_i = 1'b0;
      out_wr_i = 1'b0;
      toggle_wr_i = 1'b0;
      #1;
    end
  endtask

  task t_plain;
    begin
      wr(2'd1, 8'h5a);
      wr(2'd0, 8'h3c);
      check(pad_oe_n_o, 8'hc3);
      check(pad_out_o & 8'h3c, 8'h18);
      check(pad_pullup_o, 8'h00);
      global_pullup_disable = 1'b0;
      #1 check(pad_pullup_o, 8'h42);
    end
  endtask

  // reset mid-run releases pads before any clock edge reaches them
  task t_rst_mid;
    begin
      @(negedge mclk_i);
      reset_i = 1'b1;
      #1 check(pad_oe_n_o | pad_pullup_o, 8'hff);
      check(pad_pullup_o, 8'h00);
      repeat (3) @(negedge mclk_i);
      check(dir_o | out_o, 8'h00);
      reset_i = 1'b0;
    end
  endtask

  task t_toggle;
    begin
      wr(2'd2, 8'hff);
      check(out_o, 8'hff);
      toggle_override_en_i = 8'h81;
      @(negedge mclk_i);
      toggle_override_en_i = 8'h00;
      check(out_o, 8'h7e);
      // a frozen block must ignore both the write and the toggle override
      ce_i = 1'b0;
      toggle_override_en_i = 8'h0f;
      wr(2'd1, 8'h00);
      toggle_override_en_i = 8'h00;
      check(out_o, 8'h7e);
      ce_i = 1'b1;
    end
  endtask

  task t_timer;
    begin
      wr(2'd0, 8'hf0);
      cmp_en = 4'hf;
      repeat (8) begin
        @(negedge mclk_i);
        slow = ~slow;
        #1;
        check(pad_out_o & 8'hf0,
              {t2a, t1b, t1a, t0a, 4'h0});
      end
      wr(2'd0, 8'h00);
      check(pad_oe_n_o, 8'hff);
      cmp_en = 4'h0;
    end
  endtask

  task t_spi;
    begin
      wr(2'd0, 8'hff);
      wr(2'd1, 8'h0d);
      spi_en = 1'b1;
      spi_mst = 1'b1;
      #1 check(pad_oe_n_o, 8'h08);
      check(pad_pullup_o, 8'h08);
      repeat (4) begin
        @(negedge mclk_i);
        check(pad_out_o & 8'h06, {s_mo, s_sck, 1'b0});
      end
      spi_mst = 1'b0;
      #1 check(pad_oe_n_o, 8'h07);
      check(pad_pullup_o, 8'h05);
      repeat (4) begin
        @(negedge mclk_i);
        check(pad_out_o & 8'h08, {s_so, 3'h0});
      end
      spi_en = 1'b0;
    end
  endtask

  task t_input;
    begin
      pad_in_i = 8'h96;
      sleep = 1'b1;
      group_en = 1'b1;
      #1 check(pad_input_en_o | alt_in, 8'h00);
      pin_change_mask_i = 8'h90;
      #1 check(pad_input_en_o, 8'h90);
      check(pc_src, 8'h90);
      sleep = 1'b0;
      #1 check(alt_in, 8'h96);
      check({m_in, s_in, sck_in, ss_in}, 8'h06);
      repeat (4) @(negedge mclk_i);
      check(pin_value_o, 8'h96);
    end
  endtask

  // cut a hang short
  initial begin
    repeat (100000) @(posedge mclk_i);
    n_fail = n_fail + 1;
    tally_and_finish;
  end

  initial begin
    {mclk_i, ce_i, dir_wr_i, out_wr_i, toggle_wr_i, reset_i} = 6'h11;
    {wdata, toggle_override_en_i, pin_change_mask_i} = 24'h0;
    {global_pullup_disable, sleep, spi_en, spi_mst, group_en, slow, cmp_en} = 10'h200;
    pad_in_i = 8'h00;
    n_fail = 0;
    checks_done = 0;
    repeat (20) @(posedge mclk_i);
    #1 check(pad_oe_n_o, 8'hff);
    check(dir_o | out_o | pad_pullup_o, 8'h00);
    @(negedge mclk_i);
    reset_i = 1'b0;
    t_plain;
    t_rst_mid;
    t_toggle;
    t_timer;
    t_spi;
    t_input;
    tally_and_finish;
  end
endmodule
